// file: hdl/phase_shift_map.svh
// Purpose: Constants for the phase shift and spread control link
// Assumes: Included by both ends, not by the package
// Notes:   Offsets of the status word and timing counts
`ifndef PHASE_SHIFT_MAP_SVH
`define PHASE_SHIFT_MAP_SVH

`define NUM_WIDTH          9
`define NUM_MAX            9'sd255
`define NUM_MIN            -9'sd255
`define STATUS_WIDTH       8
`define STATUS_OVF_BIT     0
`define STATUS_LOSS_BIT    1
`define LOCK_DROP_CYCLES   4
`define LOCK_WAIT_CYCLES   16
`define SHIFT_SETTLE_CYCLES 3
`define SPREAD_MAX_TAPS    4

`endif

// file: hdl/phase_shift_pkg.sv
// Purpose: Types shared by both ends of the phase shift link
// Assumes: phase_shift_map.svh holds the numbers
// Notes:   Types only
package phase_shift_pkg;
	typedef enum logic [1:0] {SHIFT_NONE, SHIFT_FIXED, SHIFT_VARIABLE}
		shift_mode_type;
	typedef enum logic [2:0] {SPREAD_NONE, SPREAD_2, SPREAD_4, SPREAD_6,
		SPREAD_8} spread_amount_type;
endpackage : phase_shift_pkg

// file: hdl/phase_shift_if.sv
// Purpose: Link between user logic and the clock manager phase shifter
// Assumes: User end drives request and direction on shift_clock
// Notes:   No clocking block; testbench joins the ends
`timescale 1ns/1ps
interface phase_shift_if;
	logic       shift_clock;
	logic       shift_request;
	logic       shift_direction;
	logic       shift_complete;
	logic       source_clock;
	logic       feedback_clock;
	logic       reset;
	logic       locked;
	logic [7:0] status;

	modport device (
		input  shift_clock, shift_request, shift_direction,
		input  source_clock, feedback_clock, reset,
		output shift_complete, locked, status
	);
	modport user (
		output shift_clock, shift_request, shift_direction, reset,
		output feedback_clock,
		input  source_clock, shift_complete, locked, status
	);
endinterface : phase_shift_if

// file: hdl/clock_manager_shift.sv
// Operation
// - Feedback only from 1x or 2x output
// - Shift inputs held low unless variable
// - Direction high increments, low decrements
// - Numerator changes only when request high
// - Request lasts exactly one shift clock
// - Complete pulses when step takes effect
// - Complete high exactly one shift cycle
// - Next request waits for complete
// - Complete unused in none or fixed
// - Variable mode starts from configured numerator
// - Lock drops within four source cycles
// - Reset restores configured numerator
// - Reset active high, asynchronous input
// - Reset only on reconfigure or frequency change
// - Outputs invalid until lock raised
// - Hold configuration done until lock
// - Status bit zero flags numerator overflow
// - Mode none, fixed, variable; none ignores numerator
// - Numerator range minus 255 to 255
// - Spread amount gives taps one to N/2
// - Spread enable ignored when amount none
// - Spread fully on 1x outputs only
// - Shift clock may be any clock
//
// Purpose: Device end: numerator, step handshake, lock, spread taps
// Assumes: Source clock is clk_sys_i; shift clock is the link clock
// Notes:   Delay line is modelled as a tap offset output
`timescale 1ns/1ps
`include "phase_shift_map.svh"
module clock_manager_shift
	import phase_shift_pkg::*;
#(
	parameter shift_mode_type    MODE       = SHIFT_NONE,
	parameter int                INIT_SHIFT = 0,
	parameter spread_amount_type SPREAD     = SPREAD_NONE,
	parameter bit                HOLD_CONFIG = 1'b0
)
(
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_i,
	phase_shift_if.device              link,
	input  wire logic                  spread_enable_i,
	input  wire logic                  feedback_is_deskewed_i,
	output logic signed [`NUM_WIDTH-1:0] phase_offset_o,
	output logic signed [3:0]          spread_tap_1x_o,
	output logic signed [3:0]          spread_tap_other_o,
	output logic                       config_done_o
);
	// Elaboration check: the numerator register holds -255..255 only
	if (INIT_SHIFT > `NUM_MAX || INIT_SHIFT < `NUM_MIN)
	begin : g_bad_init
		$error("INIT_SHIFT out of range");
	end

	localparam logic signed [`NUM_WIDTH-1:0] INIT_NUM =
		`NUM_WIDTH'(INIT_SHIFT);

	////////////////////////////////////////////////////////////////////////
	// Reset: async input brought into each domain by two flops
	logic rst_src_m_q, rst_src_q;
	logic rst_ps_m_q, rst_ps_q;

	always_ff @(posedge clk_sys_i or posedge link.reset)
	begin
		if (link.reset)
		begin
			rst_src_m_q <= 1'b1;
			rst_src_q   <= 1'b1;
		end
		else
		begin
			rst_src_m_q <= rst_i;
			rst_src_q   <= rst_src_m_q;
		end
	end

	always_ff @(posedge link.shift_clock or posedge link.reset)
	begin
		if (link.reset)
		begin
			rst_ps_m_q <= 1'b1;
			rst_ps_q   <= 1'b1;
		end
		else
		begin
			rst_ps_m_q <= 1'b0;
			rst_ps_q   <= rst_ps_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lock: counts source cycles after reset; drops at the first source edge in reset or without deskewed feedback
	logic [4:0] lock_cnt_q;
	logic       locked_q;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_src_q || !feedback_is_deskewed_i)
		begin
			lock_cnt_q <= 5'h00;
			locked_q   <= 1'b0;
		end
		else if (lock_cnt_q != 5'(`LOCK_WAIT_CYCLES))
		begin
			lock_cnt_q <= lock_cnt_q + 5'h01;
			locked_q   <= 1'b0;
		end
		else
			locked_q <= 1'b1;
	end

	assign link.locked   = locked_q;
	assign config_done_o = HOLD_CONFIG ? locked_q : 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Step handshake on shift clock
	logic signed [`NUM_WIDTH-1:0] num_q;
	logic [1:0]                   settle_q;
	logic                         busy_q;
	logic                         done_q;
	logic                         ovf_q;
	logic                         upd_q;
	logic                         step_ok;
	logic signed [`NUM_WIDTH-1:0] num_next;

	always_comb
	begin
		num_next = link.shift_direction ? num_q + 9'sd1 : num_q - 9'sd1;
		step_ok  = link.shift_direction ? (num_q != `NUM_MAX)
			: (num_q != `NUM_MIN);
	end

	always_ff @(posedge link.shift_clock)
	begin
		if (rst_ps_q)
		begin
			num_q    <= INIT_NUM;
			busy_q   <= 1'b0;
			settle_q <= 2'h0;
			done_q   <= 1'b0;
			ovf_q    <= 1'b0;
			upd_q    <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (MODE == SHIFT_VARIABLE && link.shift_request && !busy_q)
			begin
				busy_q   <= 1'b1;
				settle_q <= 2'(`SHIFT_SETTLE_CYCLES - 1);
				if (step_ok)
				begin
					num_q <= num_next;
					ovf_q <= 1'b0;
				end
				else
					ovf_q <= 1'b1;
			end
			else if (busy_q)
			begin
				if (settle_q == 2'h0)
				begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
					upd_q  <= ~upd_q;
				end
				else
					settle_q <= settle_q - 2'h1;
			end
		end
	end

	// Stays low in none and fixed modes
	assign link.shift_complete = done_q;

	always_comb
	begin
		link.status                   = 8'h00;
		link.status[`STATUS_OVF_BIT]  = ovf_q;
		link.status[`STATUS_LOSS_BIT] = 1'b0;
	end

	// Offset word is taken only after a toggle, synchronised by two flops,
	// says a step settled; the numerator then stays frozen until the user
	// has seen complete and issued the next request.
	logic upd_m_q;
	logic upd_s_q;
	logic upd_p_q;

	always_ff @(posedge clk_sys_i)
	begin
		upd_m_q <= upd_q;
		upd_s_q <= upd_m_q;
		upd_p_q <= upd_s_q;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (MODE == SHIFT_NONE)
			phase_offset_o <= 9'sd0;
		else if (rst_src_q)
			phase_offset_o <= INIT_NUM;
		else if (upd_s_q != upd_p_q)
			phase_offset_o <= num_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Spread: walk taps -1..-k, +1..+k per source cycle
	logic signed [3:0] tap_q;
	logic              sign_q;
	logic [3:0]        half;

	always_comb
	begin
		case (SPREAD)
			SPREAD_2: half = 4'h1;
			SPREAD_4: half = 4'h2;
			SPREAD_6: half = 4'h3;
			SPREAD_8: half = 4'h4;
			default:  half = 4'h0;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_src_q || half == 4'h0 || !spread_enable_i)
		begin
			tap_q  <= 4'sh0;
			sign_q <= 1'b0;
		end
		else if ($unsigned(tap_q < 0 ? -tap_q : tap_q) >= half ||
			tap_q == 4'sh0)
		begin
			sign_q <= ~sign_q;
			tap_q  <= sign_q ? 4'sh1 : -4'sh1;
		end
		else
			tap_q <= sign_q ? tap_q - 4'sh1 : tap_q + 4'sh1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		spread_tap_1x_o    <= tap_q;
		spread_tap_other_o <= tap_q >>> 2;
	end
endmodule : clock_manager_shift

// file: hdl/shift_user.sv
// Purpose: User end: issues single phase steps on the shift clock
// Assumes: Shift clock derived by divider from clk_sys_i
// Notes:   One step outstanding at a time
`timescale 1ns/1ps
`include "phase_shift_map.svh"
module shift_user
	import phase_shift_pkg::*;
#(
	parameter shift_mode_type MODE    = SHIFT_VARIABLE,
	parameter int             DIV_HALF = 2
)
(
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	phase_shift_if.user link,
	input  wire logic step_go_i,
	input  wire logic step_up_i,
	input  wire logic deskew_clk_i,
	output logic      step_busy_o,
	output logic      step_done_o,
	output logic      overflow_o,
	output logic      locked_o
);
	// Elaboration check: the divider counter is eight bits wide
	if (DIV_HALF < 1 || DIV_HALF > 256)
	begin : g_bad_div
		$error("DIV_HALF must lie in 1..256");
	end

	logic [7:0] div_q;
	logic       sclk_q;
	logic       fall;

	assign fall = sclk_q && div_q == 8'(DIV_HALF - 1);

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || MODE != SHIFT_VARIABLE)
		begin
			div_q  <= 8'h00;
			sclk_q <= 1'b0;
		end
		else if (div_q == 8'(DIV_HALF - 1))
		begin
			div_q  <= 8'h00;
			sclk_q <= ~sclk_q;
		end
		else
			div_q <= div_q + 8'h01;
	end

	// Request and direction change on the falling shift edge only
	logic req_q, dir_q, pend_q, busy_q;
	logic done_m_q, done_s_q, done_p_q;
	logic ovf_m_q;

	always_ff @(posedge clk_sys_i)
	begin
		done_m_q <= link.shift_complete;
		done_s_q <= done_m_q;
		done_p_q <= done_s_q;
		ovf_m_q  <= link.status[`STATUS_OVF_BIT];
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || MODE != SHIFT_VARIABLE)
		begin
			req_q  <= 1'b0;
			dir_q  <= 1'b0;
			pend_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			if (step_go_i && !busy_q && !pend_q)
			begin
				pend_q <= 1'b1;
				dir_q  <= step_up_i;
			end
			if (fall)
			begin
				if (req_q)
					req_q <= 1'b0;
				else if (pend_q)
				begin
					req_q  <= 1'b1;
					pend_q <= 1'b0;
					busy_q <= 1'b1;
				end
			end
			if (done_s_q && !done_p_q)
				busy_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			step_done_o <= 1'b0;
			overflow_o  <= 1'b0;
			locked_o    <= 1'b0;
		end
		else
		begin
			step_done_o <= busy_q && done_s_q && !done_p_q;
			overflow_o  <= ovf_m_q;
			locked_o    <= link.locked;
		end
	end

	assign step_busy_o          = busy_q || pend_q;
	assign link.shift_clock     = sclk_q;
	assign link.shift_request   = req_q;
	assign link.shift_direction = req_q & dir_q;
	assign link.reset           = rst_i;
	assign link.feedback_clock  = deskew_clk_i;
endmodule : shift_user

// file: verification/phase_shift_chk.sv
// Purpose: Protocol checks on the phase shift link
// Assumes: Instantiated beside the interface in the testbench
// Notes:   Lock counter is helper logic, saturating
`timescale 1ns/1ps
module phase_shift_chk (
	input  wire logic       shift_clock,
	input  wire logic       shift_request,
	input  wire logic       shift_complete,
	input  wire logic       source_clock,
	input  wire logic       reset,
	input  wire logic       locked,
	input  wire logic [7:0] status
);
	logic [4:0] up_q;

	always_ff @(posedge source_clock or posedge reset)
		if (reset)
			up_q <= 5'h00;
		else if (up_q != 5'h1F)
			up_q <= up_q + 5'h01;
	////////////////////////////////////////
	property p_done_one;
		@(posedge shift_clock) disable iff (reset)
		shift_complete |=> !shift_complete;
	endproperty
	a_done_one: assert property (p_done_one)
		else $error("complete longer than one cycle");
	property p_done_after;
		@(posedge shift_clock) disable iff (reset)
		shift_request |-> ##[3:4] shift_complete;
	endproperty
	a_done_after: assert property (p_done_after)
		else $error("step not completed in time");
	property p_done_cause;
		@(posedge shift_clock) disable iff (reset)
		shift_complete |-> $past(shift_request, 3) || $past(shift_request, 4);
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("complete without request");
	property p_req_one;
		@(posedge shift_clock) disable iff (reset)
		shift_request |=> !shift_request;
	endproperty
	a_req_one: assert property (p_req_one)
		else $error("request longer than one cycle");
	property p_req_wait;
		@(posedge shift_clock) disable iff (reset)
		shift_request |=> !shift_request [*3];
	endproperty
	a_req_wait: assert property (p_req_wait)
		else $error("request before completion");
	property p_lock_drop;
		@(posedge source_clock) reset |-> ##[0:4] !locked;
	endproperty
	a_lock_drop: assert property (p_lock_drop)
		else $error("lock not dropped after reset");
	property p_lock_late;
		@(posedge source_clock) disable iff (reset)
		$rose(locked) |-> up_q >= 5'h10;
	endproperty
	a_lock_late: assert property (p_lock_late)
		else $error("lock raised too early");
	property p_lock_clean;
		@(posedge source_clock) disable iff (reset)
		$rose(locked) |-> !status[0];
	endproperty
	a_lock_clean: assert property (p_lock_clean)
		else $error("overflow survived reset");
endmodule : phase_shift_chk

// file: verification/testbench.sv
// Purpose: Both ends joined, steps checked against a numerator model
// Assumes: Numerator starts near the top to reach overflow
// Notes:   Shift clock comes from the user end divider
`timescale 1ns/1ps
module testbench;
	import phase_shift_pkg::*;
	localparam int INIT = 252;
	logic              clk_sys_i;
	logic              rst_i;
	logic              spread_enable_i;
	logic              step_go_i;
	logic              step_up_i;
	logic signed [8:0] phase_offset_o;
	logic signed [3:0] tap_1x;
	logic signed [3:0] tap_oth;
	logic              fb_ok;
	logic              config_done_o;
	logic              step_done_o;
	logic              overflow_o;
	logic              locked_o;
	integer            fail_count;
	integer            samples_checked;
	integer            seed;
	integer            num;
	integer            ovf;
	integer            hi;
	integer            lo;
	integer            big;
	integer            i;

	phase_shift_if link ();
	clock_manager_shift #(.MODE(SHIFT_VARIABLE), .INIT_SHIFT(INIT),
		.SPREAD(SPREAD_4), .HOLD_CONFIG(1'b1)) i_clock_manager_shift (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link),
		.spread_enable_i(spread_enable_i), .feedback_is_deskewed_i(fb_ok),
		.phase_offset_o(phase_offset_o), .spread_tap_1x_o(tap_1x),
		.spread_tap_other_o(tap_oth), .config_done_o(config_done_o));
	shift_user #(.MODE(SHIFT_VARIABLE), .DIV_HALF(2)) i_shift_user (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link),
		.step_go_i(step_go_i), .step_up_i(step_up_i),
		.deskew_clk_i(clk_sys_i), .step_busy_o(),
		.step_done_o(step_done_o), .overflow_o(overflow_o),
		.locked_o(locked_o));
	phase_shift_chk i_phase_shift_chk (.shift_clock(link.shift_clock),
		.shift_request(link.shift_request),
		.shift_complete(link.shift_complete),
		.source_clock(link.source_clock), .reset(link.reset),
		.locked(link.locked), .status(link.status));
	assign link.source_clock = clk_sys_i;
	////////////////////////////////////////
	task automatic chk(input integer seen, input integer exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen %0d exp %0d", $time, seen, exp);
		end
	endtask : chk
	task end_sim;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// Reset both ends, then wait for lock with a bounded count
	task automatic restart;
		rst_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		chk(link.locked, 0);
		chk(config_done_o, 0);
		rst_i = 1'b0;
		for (i = 0; i < 200 && locked_o !== 1'b1; i++)
			@(negedge clk_sys_i);
		chk(locked_o, 1);
		chk(config_done_o, 1);
		chk(phase_offset_o, INIT);
		chk(overflow_o, 0);
		num = INIT;
	endtask : restart
	task automatic step(input logic up);
		step_up_i = up;
		step_go_i = 1'b1;
		@(negedge clk_sys_i);
		step_go_i = 1'b0;
		for (i = 0; i < 200 && step_done_o !== 1'b1; i++)
			@(negedge clk_sys_i);
		chk(step_done_o, 1);
		ovf = (up && num == 255) || (!up && num == -255);
		if (!ovf)
			num = up ? num + 1 : num - 1;
		chk(phase_offset_o, num);
		chk(overflow_o, ovf);
		@(negedge clk_sys_i);
		chk(step_done_o, 0);
		@(negedge clk_sys_i);
	endtask : step
	////////////////////////////////////////
	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	initial
	begin
		// Far above the sum of every bounded wait in the tests
		#1000000;
		fail_count++;
		end_sim;
	end
	initial
	begin
		fail_count = 0;
		samples_checked = 0;
		seed = 9294;
		rst_i = 1'b1;
		spread_enable_i = 1'b1;
		fb_ok = 1'b1;
		step_go_i = 1'b0;
		step_up_i = 1'b0;
		restart;
		hi = 0;
		lo = 0;
		big = 0;
		repeat (16)
		begin
			@(negedge clk_sys_i);
			if (tap_1x > hi)
				hi = tap_1x;
			if (tap_1x < lo)
				lo = tap_1x;
			if (tap_oth > 1 || tap_oth < -1)
				big++;
		end
		chk(hi, 2);
		chk(lo, -2);
		chk(big, 0);
		spread_enable_i = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		chk(tap_1x, 0);
		repeat (4) step(1'b1);
		step(1'b0);
		repeat (10) step(1'($random(seed)));
		restart;
		step(1'b1);
		// Feedback from anything but the deskewed output must lose lock
		fb_ok = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk(link.locked, 0);
		fb_ok = 1'b1;
		end_sim;
	end
endmodule : testbench
